// ===== design/gpc_pin_cell.sv
`timescale 1ns/1ps
module gpc_pin_cell (
  // configuration
  input  wire logic isInput,
  input  wire logic invert,
  input  wire logic openDrain,
  // value to present, before polarity
  input  wire logic outValue,
  // pin side, combinational
  output logic      padOut,
  output logic      padOe
);
  logic level;
  always_comb begin
    level = outValue ^ invert;
    // open drain only ever pulls low
    if (isInput) begin
      padOut = 1'b0;
      padOe  = 1'b0;
    end else if (openDrain) begin
      padOut = 1'b0;
      padOe  = ~level;
    end else begin
      padOut = level;
      padOe  = 1'b1;
    end
  end
endmodule : gpc_pin_cell

// ===== design/gpc_pin_config_group.sv
`timescale 1ns/1ps
module gpc_pin_config_group (
  // clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          srst,
  input  wire logic                          standbyPowerOnReset,
  // avalon-mm slave
  input  wire logic [gpc_pkg::ADDR_W-1:0]    avsAddress,
  input  wire logic                          avsRead,
  input  wire logic                          avsWrite,
  input  wire logic [31:0]                   avsWritedata,
  input  wire logic [3:0]                    avsByteenable,
  output logic      [31:0]                   avsReaddata,
  output logic                               avsWaitrequest,
  output logic [1:0]                         avsResponse,
  // alternate function sources
  input  wire logic                          gateA20Out,
  input  wire logic                          driveDensityBit0,
  input  wire logic                          driveDensityBit1,
  input  wire logic                          pmEventOutN,
  // pins: three signals each
  input  wire logic [gpc_pkg::NPIN-1:0]      pinIn,
  output logic      [gpc_pkg::NPIN-1:0]      pinOut,
  output logic      [gpc_pkg::NPIN-1:0]      pinOe,
  // device-disable register and interrupt
  output logic      [7:0]                    devDisable,
  output logic                               disableRegWriteGuard,
  output logic                               irq
);
  import gpc_pkg::*;

  // ==========================================================
  // input synchronisers
  logic [NPIN-1:0] pinSync;
  gpc_sync u_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .asyncIn  (pinIn),
    .syncOut  (pinSync)
  );

  // ==========================================================
  // registers
  logic [7:0] cfg_reg [NPIN];
  logic [7:0] cfg_next [NPIN];
  logic [7:0] devDisable_reg;
  logic [7:0] devDisable_next;
  logic [1:0] irqStatus_reg;
  logic [1:0] irqStatus_next;
  logic [1:0] irqMask_reg;
  logic [1:0] irqMask_next;
  logic [NPIN-1:0] pinPrev_reg;
  logic [NPIN-1:0] pinPrev_next;
  logic [31:0] readData_reg;
  logic [31:0] readData_next;
  logic waitReq_reg;
  logic waitReq_next;
  logic [1:0] resp_reg;
  logic [1:0] resp_next;
  logic [NPIN-1:0] padOut_reg;
  logic [NPIN-1:0] padOe_reg;
  logic [NPIN-1:0] padOut_w;
  logic [NPIN-1:0] padOe_w;
  logic guard_reg;
  logic guard_next;
  logic irq_reg;
  logic irq_next;
  logic [NPIN-1:0] pinLevel;
  // main-power, hard and standby-power reset clear the same state, save the input synchronisers, which only srst clears
  logic anyReset;
  assign anyReset = srst | standbyPowerOnReset;

  // ==========================================================
  // bus decode: one wait state, answer on second edge of request
  logic        accept;
  logic        complete;
  logic [7:0]  index;
  logic        wordAligned;
  logic [7:0]  wrByte;
  logic        wrLane0;
  logic        guardSel;
  logic        lockField;
  logic        edge2Sel;
  logic        edge3Sel;
  logic [1:0]  edgeHit;

  always_comb begin
    accept      = (avsRead | avsWrite) & waitReq_reg;
    // writes land on the edge that ends the transfer, not at acceptance
    complete    = (avsRead | avsWrite) & ~waitReq_reg;
    wordAligned = (avsAddress[1:0] == 2'h0);
    index       = avsAddress[ADDR_W-1:2];
    wrByte      = avsWritedata[7:0];
    wrLane0     = avsWrite & complete & avsByteenable[0];
    guardSel    = (cfg_reg[P43][3:2] == FN_ALT1);
    lockField   = guardSel;
    edge2Sel    = (cfg_reg[P41][3:2] == FN_ALT2);
    edge3Sel    = (cfg_reg[P43][3:2] == FN_ALT3);
    edgeHit[IRQ_EDGE2] = edge2Sel & (pinSync[P41] ^ pinPrev_reg[P41]);
    edgeHit[IRQ_EDGE3] = edge3Sel & (pinSync[P43] ^ pinPrev_reg[P43]);
  end

  // ==========================================================
  // bus answer: data and response stand for one cycle only
  always_comb begin
    waitReq_next  = ~accept;
    resp_next     = 2'h0;
    readData_next = '0;
    if (accept) begin
      if (!wordAligned) begin
        // unaligned lanes are refused rather than guessed at
        resp_next = 2'h2;
      end else begin
        case (index)
          IDX_PIN37: readData_next[7:0] = cfg_reg[P37];
          IDX_PIN40: readData_next[7:0] = cfg_reg[P40];
          IDX_PIN41: readData_next[7:0] = cfg_reg[P41];
          IDX_PIN42: readData_next[7:0] = cfg_reg[P42];
          IDX_PIN43: readData_next[7:0] = cfg_reg[P43];
          IDX_IRQ_STATUS: readData_next[1:0] = irqStatus_reg;
          IDX_IRQ_MASK: readData_next[1:0] = irqMask_reg;
          IDX_PIN_LEVEL: readData_next[NPIN-1:0] = pinLevel;
          IDX_DEV_DISABLE: readData_next[7:0] = devDisable_reg;
          default: resp_next = 2'h2;
        endcase
      end
      // a write answers with zero data
      if (avsWrite) begin
        readData_next = '0;
      end
    end
  end

  // ==========================================================
  // configuration registers
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      cfg_next[i] = cfg_reg[i];
    end
    if (wrLane0 && wordAligned) begin
      case (index)
        IDX_PIN37: cfg_next[P37] = wrByte & MASK_ONEBIT;
        IDX_PIN40: cfg_next[P40] = wrByte & MASK_ONEBIT;
        IDX_PIN41: cfg_next[P41] = wrByte & MASK_TWOBIT;
        IDX_PIN42: cfg_next[P42] = wrByte & MASK_ONEBIT;
        IDX_PIN43: begin
          cfg_next[P43] = wrByte & MASK_TWOBIT;
          // once locked, only a reset frees the field
          if (lockField) begin
            cfg_next[P43][3:2] = FN_ALT1;
          end
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // device-disable register and its write guard
  always_comb begin
    devDisable_next = devDisable_reg;
    if (wrLane0 && wordAligned && (index == IDX_DEV_DISABLE)) begin
      // guard high blocks the write, low lets it through
      if (!(guardSel && pinSync[P43])) begin
        devDisable_next = wrByte;
      end
    end
    // guard level ignores the polarity bit
    guard_next = guardSel & pinSync[P43];
  end

  // ==========================================================
  // interrupt status, mask and edge history
  always_comb begin
    pinPrev_next   = pinSync;
    irqMask_next   = irqMask_reg;
    irqStatus_next = irqStatus_reg;
    if (wrLane0 && wordAligned && (index == IDX_IRQ_MASK)) begin
      irqMask_next = wrByte[1:0];
    end
    // only a write to the status index clears, one bit per one written
    if (wrLane0 && wordAligned && (index == IDX_IRQ_STATUS)) begin
      irqStatus_next = irqStatus_reg & ~wrByte[1:0];
    end
    // hardware set wins over write-one clear
    irqStatus_next = irqStatus_next | edgeHit;
    irq_next       = |(irqStatus_next & irqMask_next);
  end

  // ==========================================================
  // pin drive, one cell per pin
  logic [NPIN-1:0] altOn;
  logic [NPIN-1:0] altVal;
  logic [NPIN-1:0] forceIn;
  always_comb begin
    altOn   = '0;
    altVal  = '0;
    forceIn = '0;
    altOn[P37]  = cfg_reg[P37][BIT_ALT];
    altVal[P37] = gateA20Out;
    altOn[P40]  = cfg_reg[P40][BIT_ALT];
    altVal[P40] = driveDensityBit0;
    altOn[P41]  = (cfg_reg[P41][3:2] == FN_ALT1);
    altVal[P41] = driveDensityBit1;
    // active-low source passes straight; non-inverted output stays active low
    altOn[P42]  = cfg_reg[P42][BIT_ALT];
    altVal[P42] = pmEventOutN;
    forceIn[P41] = edge2Sel;
    forceIn[P43] = guardSel | edge3Sel;
    // read-back goes through the polarity bit; forced inputs stay straight
    for (int i = 0; i < NPIN; i++) begin
      pinLevel[i] = pinSync[i] ^ (cfg_reg[i][BIT_POL] & ~forceIn[i]);
    end
  end

  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_pin
      gpc_pin_cell u_cell (
        .isInput   (cfg_reg[g][BIT_DIR] | forceIn[g]),
        .invert    (cfg_reg[g][BIT_POL] & ~forceIn[g]),
        .openDrain (cfg_reg[g][BIT_OD]),
        // plain gpio output data has no register here; it drives zero
        .outValue  (altOn[g] & altVal[g]),
        .padOut    (padOut_w[g]),
        .padOe     (padOe_w[g])
      );
    end
  endgenerate

  // ==========================================================
  // registering: bus answer
  always_ff @(posedge core_clk) begin
    if (anyReset) begin
      readData_reg <= '0;
      waitReq_reg  <= 1'b1;
      resp_reg     <= 2'h0;
    end else begin
      readData_reg <= readData_next;
      waitReq_reg  <= waitReq_next;
      resp_reg     <= resp_next;
    end
  end

  // ==========================================================
  // registering: configuration, device disable, guard
  always_ff @(posedge core_clk) begin
    if (anyReset) begin
      for (int i = 0; i < NPIN; i++) begin
        cfg_reg[i] <= CFG_RESET;
      end
      devDisable_reg <= DEV_DISABLE_RESET;
      guard_reg      <= 1'b0;
    end else begin
      for (int i = 0; i < NPIN; i++) begin
        cfg_reg[i] <= cfg_next[i];
      end
      devDisable_reg <= devDisable_next;
      guard_reg      <= guard_next;
    end
  end

  // ==========================================================
  // registering: interrupts
  always_ff @(posedge core_clk) begin
    if (anyReset) begin
      irqStatus_reg <= '0;
      irqMask_reg   <= '0;
      pinPrev_reg   <= '0;
      irq_reg       <= 1'b0;
    end else begin
      irqStatus_reg <= irqStatus_next;
      irqMask_reg   <= irqMask_next;
      pinPrev_reg   <= pinPrev_next;
      irq_reg       <= irq_next;
    end
  end

  // ==========================================================
  // registering: pin drive, released while in reset
  always_ff @(posedge core_clk) begin
    if (anyReset) begin
      padOut_reg <= '0;
      padOe_reg  <= '0;
    end else begin
      padOut_reg <= padOut_w;
      padOe_reg  <= padOe_w;
    end
  end

  assign avsReaddata          = readData_reg;
  assign avsWaitrequest       = waitReq_reg;
  assign avsResponse          = resp_reg;
  assign pinOut               = padOut_reg;
  assign pinOe                = padOe_reg;
  assign devDisable           = devDisable_reg;
  assign disableRegWriteGuard = guard_reg;
  assign irq                  = irq_reg;
endmodule : gpc_pin_config_group

// ===== design/gpc_pkg.sv
package gpc_pkg;
  // ==========================================================
  // register map, byte addresses are four times the index
  localparam logic [7:0] IDX_PIN37 = 8'h3A;
  localparam logic [7:0] IDX_PIN40 = 8'h3B;
  localparam logic [7:0] IDX_PIN41 = 8'h3C;
  localparam logic [7:0] IDX_PIN42 = 8'h3D;
  localparam logic [7:0] IDX_PIN43 = 8'h3E;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h50;
  localparam logic [7:0] IDX_IRQ_MASK   = 8'h51;
  localparam logic [7:0] IDX_PIN_LEVEL  = 8'h52;
  localparam logic [7:0] IDX_DEV_DISABLE = 8'h53;
  localparam int ADDR_W = 10;
  // ==========================================================
  // fields
  localparam int BIT_DIR = 0;
  localparam int BIT_POL = 1;
  localparam int BIT_ALT = 2;
  localparam int BIT_OD  = 7;
  localparam logic [1:0] FN_GPIO = 2'h0;
  localparam logic [1:0] FN_ALT1 = 2'h1;
  localparam logic [1:0] FN_ALT2 = 2'h2;
  localparam logic [1:0] FN_ALT3 = 2'h3;
  localparam logic [7:0] CFG_RESET = 8'h01;
  localparam logic [7:0] DEV_DISABLE_RESET = 8'h00;
  // masks of writable bits, reserved bits read zero
  localparam logic [7:0] MASK_ONEBIT = 8'h87;
  localparam logic [7:0] MASK_TWOBIT = 8'h8F;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam int NPIN = 5;
  // pin indexes in vectors
  localparam int P37 = 0;
  localparam int P40 = 1;
  localparam int P41 = 2;
  localparam int P42 = 3;
  localparam int P43 = 4;
  // interrupt status bits
  localparam int IRQ_EDGE2 = 0;
  localparam int IRQ_EDGE3 = 1;
endpackage : gpc_pkg

// ===== design/gpc_sync.sv
`timescale 1ns/1ps
module gpc_sync (
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   srst,
  // levels
  input  wire logic [gpc_pkg::NPIN-1:0] asyncIn,
  output logic      [gpc_pkg::NPIN-1:0] syncOut
);
  import gpc_pkg::*;
  logic [NPIN-1:0] stageOne_reg;
  logic [NPIN-1:0] stageOne_next;
  logic [NPIN-1:0] stageTwo_reg;
  logic [NPIN-1:0] stageTwo_next;

  always_comb begin
    stageOne_next = asyncIn;
    stageTwo_next = stageOne_reg;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      stageOne_reg <= '0;
      stageTwo_reg <= '0;
    end else begin
      stageOne_reg <= stageOne_next;
      stageTwo_reg <= stageTwo_next;
    end
  end

  assign syncOut = stageTwo_reg;
endmodule : gpc_sync

// ===== test/gpc_pin_config_group_sva.sv
`timescale 1ns/1ps
module gpc_pin_config_group_sva
  import gpc_pkg::*;
(
  // clock and reset
  input wire logic                core_clk,
  input wire logic                srst,
  input wire logic                standbyPowerOnReset,
  // bus and pins
  input wire logic                avsRead,
  input wire logic                avsWrite,
  input wire logic [31:0]         avsReaddata,
  input wire logic                avsWaitrequest,
  input wire logic [1:0]          avsResponse,
  input wire logic [NPIN-1:0]     pinIn,
  input wire logic [NPIN-1:0]     pinOe,
  input wire logic [7:0]          devDisable,
  input wire logic                disableRegWriteGuard,
  input wire logic                irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst || standbyPowerOnReset);
  // ==========================================================
  // bus handshake
  a_wait_one: assert property ((avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest)
    else $error("access not answered after one cycle");
  a_wait_pulse: assert property (!avsWaitrequest |=> avsWaitrequest)
    else $error("waitrequest low longer than one cycle");
  a_answer_cause: assert property (!avsWaitrequest |-> $past(avsRead || avsWrite))
    else $error("answer without a request");
  a_rdata_idle: assert property (avsWaitrequest |-> avsReaddata == 32'h0)
    else $error("read data not zero outside answer");
  a_rdata_high: assert property (!avsWaitrequest |-> avsReaddata[31:8] == 24'h0 && avsResponse != 2'h1)
    else $error("upper read data or response code bad");
  // ==========================================================
  // reset, guard
  a_reset_clear: assert property ($fell(srst) |-> pinOe == '0 && !irq && devDisable == 8'h00)
    else $error("outputs not cleared by reset");
  a_guard_input: assert property (disableRegWriteGuard |-> !pinOe[P43])
    else $error("guard pin driven");
  a_guard_pin: assert property (disableRegWriteGuard |-> $past(pinIn[P43], 2) || $past(pinIn[P43], 3)
    || $past(pinIn[P43], 4))
    else $error("guard high while pin low");
  a_disable_frozen: assert property (
    disableRegWriteGuard && $past(disableRegWriteGuard) |-> $stable(devDisable))
    else $error("disable register changed under guard");
endmodule : gpc_pin_config_group_sva

bind gpc_pin_config_group gpc_pin_config_group_sva u_sva (.core_clk(core_clk), .srst(srst),
  .standbyPowerOnReset(standbyPowerOnReset), .avsRead(avsRead), .avsWrite(avsWrite),
  .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .avsResponse(avsResponse),
  .pinIn(pinIn), .pinOe(pinOe), .devDisable(devDisable),
  .disableRegWriteGuard(disableRegWriteGuard), .irq(irq));

// ===== test/gpc_pin_config_group_tb.sv
`timescale 1ns/1ps
module gpc_pin_config_group_tb;
  import gpc_pkg::*;
  logic              core_clk, srst, standbyPowerOnReset, avsRead, avsWrite, avsWaitrequest;
  logic [ADDR_W-1:0] avsAddress;
  logic [31:0]       avsWritedata, avsReaddata, rdata;
  logic [3:0]        avsByteenable;
  logic [1:0]        avsResponse, rresp;
  logic              gateA20Out, driveDensityBit0, driveDensityBit1, pmEventOutN, disableRegWriteGuard, irq;
  logic [NPIN-1:0]   pinIn, pinOut, pinOe;
  logic [7:0]        devDisable;
  int                n_mismatch = 0;
  int                tests_run = 0;

  gpc_pin_config_group uut (.core_clk(core_clk), .srst(srst), .standbyPowerOnReset(standbyPowerOnReset),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
    .avsByteenable(avsByteenable), .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
    .avsResponse(avsResponse), .gateA20Out(gateA20Out), .driveDensityBit0(driveDensityBit0),
    .driveDensityBit1(driveDensityBit1), .pmEventOutN(pmEventOutN), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe), .devDisable(devDisable), .disableRegWriteGuard(disableRegWriteGuard), .irq(irq));

  // ==========================================================
  // helpers
  task automatic finish_test();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  // held until the edge that samples waitrequest low
  task automatic access(input logic [7:0] idx, input logic wr, input logic [7:0] wdata);
    int n;
    n = 0;
    @(posedge core_clk);
    avsAddress <= {idx, 2'h0};
    avsWrite <= wr;
    avsRead <= !wr;
    avsWritedata <= {24'h0, wdata};
    do begin
      @(posedge core_clk);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 50);
    rdata = avsReaddata;
    rresp = avsResponse;
    if (n >= 50) n_mismatch++;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask : access

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    access(idx, 1'b0, 8'h00);
    check(rdata, {24'h0, exp});
  endtask : rd

  task automatic pinchk(input logic [7:0] idx, input logic [7:0] cfg, input int p, input logic eo, input logic ee);
    access(idx, 1'b1, cfg);
    repeat (3) @(posedge core_clk);
    check({30'h0, pinOut[p], pinOe[p]}, {30'h0, eo, ee});
  endtask : pinchk

  // ==========================================================
  // clock, timeout
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    repeat (4000) @(posedge core_clk);
    n_mismatch++;
    finish_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    srst = 1'b1; standbyPowerOnReset = 1'b0; avsRead = 1'b0; avsWrite = 1'b0;
    avsAddress = '0; avsWritedata = '0; avsByteenable = 4'hF; pinIn = '0;
    // sources differ from the plain output level 0
    gateA20Out = 1'b1; driveDensityBit0 = 1'b1; driveDensityBit1 = 1'b1; pmEventOutN = 1'b1;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    for (int i = 0; i < NPIN; i++) rd(8'(IDX_PIN37 + i), CFG_RESET);
    check({27'h0, pinOe}, 32'h0);
    pinchk(IDX_PIN37, 8'h00, P37, 1'b0, 1'b1);
    pinchk(IDX_PIN37, 8'h02, P37, 1'b1, 1'b1);
    pinchk(IDX_PIN37, 8'h80, P37, 1'b0, 1'b1);
    pinchk(IDX_PIN37, 8'h82, P37, 1'b0, 1'b0);
    pinchk(IDX_PIN37, 8'h04, P37, 1'b1, 1'b1);
    pinchk(IDX_PIN40, 8'h04, P40, 1'b1, 1'b1);
    pinchk(IDX_PIN41, 8'h04, P41, 1'b1, 1'b1);
    pinchk(IDX_PIN42, 8'h04, P42, 1'b1, 1'b1);
    pinchk(IDX_PIN42, 8'h84, P42, 1'b0, 1'b0);
    // active event pulls the open-drain pin low
    pmEventOutN <= 1'b0;
    pinchk(IDX_PIN42, 8'h84, P42, 1'b0, 1'b1);
    // lane 0 off: write must not land
    avsByteenable <= 4'hE;
    access(IDX_PIN40, 1'b1, 8'hFF);
    avsByteenable <= 4'hF;
    rd(IDX_PIN40, 8'h04);
    access(8'hFF, 1'b0, 8'h00);
    check({30'h0, rresp}, 32'h2);
    // edge interrupts, masked first then unmasked, cleared by one
    access(IDX_PIN41, 1'b1, 8'h08);
    access(IDX_PIN43, 1'b1, 8'h0C);
    for (int k = 0; k < 2; k++) begin
      access(IDX_IRQ_MASK, 1'b1, 8'h00);
      pinIn[k == 0 ? P41 : P43] <= 1'b1;
      repeat (6) @(posedge core_clk);
      check({31'h0, irq}, 32'h0);
      rd(IDX_IRQ_STATUS, 8'(1 << k));
      access(IDX_IRQ_MASK, 1'b1, 8'h03);
      repeat (3) @(posedge core_clk);
      check({31'h0, irq}, 32'h1);
      access(IDX_IRQ_STATUS, 1'b1, 8'(1 << k));
      repeat (3) @(posedge core_clk);
      check({31'h0, irq}, 32'h0);
    end
    // guard lock and write protection, pin 4.3 still high
    access(IDX_PIN43, 1'b1, 8'h05);
    access(IDX_PIN43, 1'b1, 8'h09);
    rd(IDX_PIN43, 8'h05);
    repeat (4) @(posedge core_clk);
    check({31'h0, disableRegWriteGuard}, 32'h1);
    access(IDX_DEV_DISABLE, 1'b1, 8'hA5);
    rd(IDX_DEV_DISABLE, 8'h00);
    pinIn[P43] <= 1'b0;
    repeat (4) @(posedge core_clk);
    access(IDX_DEV_DISABLE, 1'b1, 8'hA5);
    rd(IDX_DEV_DISABLE, 8'hA5);
    check({24'h0, devDisable}, 32'hA5);
    // inverted input on 3.7 reads high; forced inputs read straight
    access(IDX_PIN37, 1'b1, 8'h03);
    rd(IDX_PIN_LEVEL, 8'h05);
    standbyPowerOnReset <= 1'b1;
    @(posedge core_clk);
    standbyPowerOnReset <= 1'b0;
    rd(IDX_PIN43, CFG_RESET);
    finish_test();
  end
endmodule : gpc_pin_config_group_tb
